// >>> codec_regs.v
// control and status register bank with power sequencing for an audio codec
//
// Overview of operation
// R1: ready flags are read-only; writes to their positions change nothing.
// R2: a ready flag reads 1 only when its subsection works normally.
// R3: software sets the three lowest request bits one at a time.
// R4: bit 3 powers down mixer and reference only with ADC and DAC down.
// R5: bit 5 acts only when ADC, DAC and link are already down.
// R6: host lets power-up sequences finish before setting bits 5 and 4.
// R7: primary codec bits 5 and 4 govern secondaries; own bit 4 gates bit 5.
// R8: amplifier shutdown bit drives its pin: 0 low enables, 1 high shuts off.
// R9: bit 0 ADC, bit 1 DAC, 0/1/4/5 clocks stop, bit 6 headphone standby.
// R10: variable-rate and S/PDIF support bits read 1, read-only.
// R11: DAC slot field resets 00 and maps DAC pair to link slots.
// R12: compliance level reads 01; slot map by configuration bit reads 1.
// R13: configuration code reports strap: 00 primary, others secondary.
// R14: variable rate off means fixed 48 kHz; on uses rate registers.
// R15: S/PDIF enable sticks only when strap pulled low; else reads 0.
// R16: S/PDIF slot field resets by configuration and channel count.
// R17: config-ok flag always reports whether S/PDIF setup is supported.
// R18: validity flag from error detection, forced high, or forced low.
// R19: rate registers hold 16-bit hertz, 1B58h to BB80h, reset BB80h.
// R20: writing 0 to variable rate returns both rates to 48 kHz.
// R21: loopback bit routes ADC data digitally into the DAC path.
// R22: software reads general-purpose register and masks its writes.
`timescale 1ns/1ps
`default_nettype none
`include "codec_regs_defines.vh"

module codec_regs #(
	parameter CHANNELS = 2
) (
	// clock and reset
	input  wire        CLK_I,
	input  wire        RST_I,
	// register port
	input  wire [6:0]  ADDR_I,
	input  wire [15:0] WDATA_I,
	input  wire        WE_I,
	input  wire        RE_I,
	output reg  [15:0] RDATA_O,
	// straps, sampled while reset is held
	input  wire [1:0]  CFG_STRAP_I,
	input  wire        SPDIF_STRAP_N_I,
	// power-down requests of the primary codec
	input  wire        PRIMARY_REQ4_I,
	input  wire        PRIMARY_REQ5_I,
	// subsection settled levels from the analog side
	input  wire        ADC_SETTLED_I,
	input  wire        DAC_SETTLED_I,
	input  wire        MIX_SETTLED_I,
	input  wire        REF_SETTLED_I,
	// sample error detection
	input  wire        SAMPLE_ERR_I,
	// power controls
	output reg         ADC_PWRDN_O,
	output reg         DAC_PWRDN_O,
	output reg         MIX_PWRDN_O,
	output reg         REF_PWRDN_O,
	output reg         LINK_PWRDN_O,
	output reg         CLK_STOP_O,
	output reg         HP_STANDBY_O,
	output reg         EXT_AMP_SHUTDOWN_O,
	// datapath controls
	output reg         DIGITAL_LOOPBACK_O,
	output reg         VAR_RATE_O,
	output reg  [1:0]  DAC_SLOT_SEL_O,
	output reg  [1:0]  SPDIF_SLOT_SEL_O,
	output reg         SPDIF_EN_O,
	output reg         VALIDITY_O,
	output reg  [15:0] DAC_RATE_O,
	output reg  [15:0] ADC_RATE_O
);

	// ==========================================================
	// state
	reg  [6:0]  req_q;
	reg         ext_amp_q;
	reg         loopback_q;
	reg  [1:0]  cfg_q;
	reg         spdif_ok_q;
	reg  [1:0]  dsa_q;
	reg         vra_q;
	reg         spdif_en_q;
	reg  [1:0]  spsa_q;
	reg         validity_override_q;
	reg         flag_q;
	reg  [1:0]  spdif_tx_rate_sel_q;
	reg         drs_q;
	reg  [15:0] dac_rate_q;
	reg  [15:0] adc_rate_q;
	reg         adc_rdy_q;
	reg         dac_rdy_q;
	reg         mix_rdy_q;
	reg         ref_rdy_q;
	reg         spdif_config_ok_q;

	// ==========================================================
	// write strobes and strap-dependent slot default
	wire        wr_gp   = WE_I && (ADDR_I == `OFS_GENERAL_PURPOSE);
	wire        wr_pd   = WE_I && (ADDR_I == `OFS_POWER_DOWN);
	wire        wr_cap  = WE_I && (ADDR_I == `OFS_EXT_CAP_ID);
	wire        wr_esc  = WE_I && (ADDR_I == `OFS_EXT_STAT_CTRL);
	wire        wr_dacr = WE_I && (ADDR_I == `OFS_FRONT_DAC_RATE);
	wire        wr_adcr = WE_I && (ADDR_I == `OFS_ADC_RATE);
	wire        wr_spc  = WE_I && (ADDR_I == `OFS_SPDIF_CTRL);
	wire        wr_rm   = WE_I && (ADDR_I == `OFS_RATE_MODE);
	reg  [1:0]  spsa_rst;

	// default slot select per configuration and channel count
	always @* begin
		if (CFG_STRAP_I == `CFG_PRIMARY) begin
			if (CHANNELS >= 6)
				spsa_rst = `SLOT_10_11; // R16
			else if (CHANNELS >= 4)
				spsa_rst = `SLOT_6_9; // R16
			else
				spsa_rst = `SLOT_7_8; // R16
		end else if (CFG_STRAP_I == `CFG_SECONDARY_3 || CHANNELS >= 4) begin
			spsa_rst = `SLOT_10_11; // R16
		end else begin
			spsa_rst = `SLOT_6_9; // R16
		end
	end

	// clamp a written rate into the legal span
	function [15:0] clamp_rate;
		input [15:0] r;
		begin
			if (r < `RATE_MIN)
				clamp_rate = `RATE_MIN;
			else if (r > `RATE_48K)
				clamp_rate = `RATE_48K;
			else
				clamp_rate = r;
		end
	endfunction

	// ==========================================================
	// software-written registers; straps caught while reset is held
	always @(posedge CLK_I) begin
		if (RST_I) begin
			req_q      <= 7'h00;
			ext_amp_q  <= 1'b0;
			loopback_q <= 1'b0;
			cfg_q      <= CFG_STRAP_I; // R13
			spdif_ok_q <= ~SPDIF_STRAP_N_I; // R15
			dsa_q      <= `SLOT_3_4; // R11
			vra_q      <= 1'b0;
			spdif_en_q <= 1'b0;
			spsa_q     <= spsa_rst; // R16
			validity_override_q   <= 1'b0;
			flag_q     <= 1'b0;
			spdif_tx_rate_sel_q     <= `SPDIF_TX_RATE_SEL_RESET;
			drs_q      <= 1'b0;
			dac_rate_q <= `RATE_48K; // R19
			adc_rate_q <= `RATE_48K; // R19
		end else begin
			if (wr_gp)
				loopback_q <= WDATA_I[`GP_LOOPBACK_BIT]; // R21
			// ready bits in the low nibble are not stored
			if (wr_pd) begin
				ext_amp_q <= WDATA_I[`PD_EXT_AMP_BIT]; // R8
				req_q     <= WDATA_I[`PD_REQ_HI:`PD_REQ_LO]; // R1
			end
			if (wr_cap)
				dsa_q <= WDATA_I[`DSA_HI:`DSA_LO]; // R11
			if (wr_esc) begin
				vra_q      <= WDATA_I[`ESC_VRA_BIT];
				spdif_en_q <= WDATA_I[`ESC_SPDIF_BIT] & spdif_ok_q; // R15
				spsa_q     <= WDATA_I[`ESC_SPSA_HI:`ESC_SPSA_LO];
				validity_override_q   <= WDATA_I[`ESC_VALIDITY_OVERRIDE_BIT];
			end
			if (wr_spc) begin
				flag_q <= WDATA_I[`SPC_FLAG_BIT];
				spdif_tx_rate_sel_q <= WDATA_I[`SPC_RATE_HI:`SPC_RATE_LO];
			end
			if (wr_rm)
				drs_q <= WDATA_I[`RM_DRS_BIT];
			// rates follow writes only in variable-rate mode
			if (wr_esc && !WDATA_I[`ESC_VRA_BIT]) begin
				dac_rate_q <= `RATE_48K; // R20
				adc_rate_q <= `RATE_48K; // R20
			end else begin
				if (wr_dacr && vra_q)
					dac_rate_q <= clamp_rate(WDATA_I); // R14
				if (wr_adcr && vra_q)
					adc_rate_q <= clamp_rate(WDATA_I); // R14
			end
		end
	end

	// ==========================================================
	// effective power state
	wire secondary = (cfg_q != `CFG_PRIMARY);
	wire adc_down  = req_q[0]; // R9
	wire dac_down  = req_q[1]; // R9
	wire ref_down  = req_q[3] & adc_down & dac_down; // R4
	wire mix_down  = req_q[2] | ref_down; // R4
	// a secondary follows the primary; its own bit 4 only gates its bit 5
	wire link_down = secondary ? PRIMARY_REQ4_I : req_q[4]; // R7
	wire req5      = secondary ? (PRIMARY_REQ5_I | (req_q[5] & req_q[4])) : req_q[5]; // R7
	wire clk_stop  = req5 & adc_down & dac_down & link_down; // R5
	// converters and mixer stay down until the reference is up; a clock stop leaves mixer and reference alone
	wire ref_up    = ~ref_down & REF_SETTLED_I; // R4

	// power outputs and ready flags
	always @(posedge CLK_I) begin
		if (RST_I) begin
			ADC_PWRDN_O  <= 1'b0;
			DAC_PWRDN_O  <= 1'b0;
			MIX_PWRDN_O  <= 1'b0;
			REF_PWRDN_O  <= 1'b0;
			LINK_PWRDN_O <= 1'b0;
			CLK_STOP_O   <= 1'b0;
			HP_STANDBY_O <= 1'b0;
			adc_rdy_q    <= 1'b0;
			dac_rdy_q    <= 1'b0;
			mix_rdy_q    <= 1'b0;
			ref_rdy_q    <= 1'b0;
		end else begin
			ADC_PWRDN_O  <= adc_down | ~ref_up | clk_stop; // R4
			DAC_PWRDN_O  <= dac_down | ~ref_up | clk_stop; // R4
			MIX_PWRDN_O  <= mix_down | ~ref_up; // R4
			REF_PWRDN_O  <= ref_down; // R4
			LINK_PWRDN_O <= link_down;
			CLK_STOP_O   <= clk_stop; // R9
			HP_STANDBY_O <= req_q[6]; // R9
			adc_rdy_q    <= ~adc_down & ref_up & ADC_SETTLED_I; // R2
			dac_rdy_q    <= ~dac_down & ref_up & DAC_SETTLED_I; // R2
			mix_rdy_q    <= ~mix_down & ref_up & MIX_SETTLED_I; // R2
			ref_rdy_q    <= ref_up; // R2
		end
	end

	// ==========================================================
	// spdif configuration check, independent of the enable bit
	wire [15:0] dac_slot_rate = vra_q ? dac_rate_q : `RATE_48K;
	wire        rate_ok = ((spdif_tx_rate_sel_q == `SPDIF_TX_RATE_SEL_48K) && (dac_slot_rate == `RATE_48K)) ||
	                      ((spdif_tx_rate_sel_q == `SPDIF_TX_RATE_SEL_44K1) && (dac_slot_rate == `RATE_44K1));
	wire        slot_ok = (spsa_q != dsa_q) ||
	                      (secondary && (cfg_q != `CFG_SECONDARY_3));

	// datapath outputs and validity selection
	always @(posedge CLK_I) begin
		if (RST_I) begin
			spdif_config_ok_q             <= 1'b0;
			EXT_AMP_SHUTDOWN_O <= 1'b0;
			DIGITAL_LOOPBACK_O <= 1'b0;
			VAR_RATE_O         <= 1'b0;
			DAC_SLOT_SEL_O     <= `SLOT_3_4;
			SPDIF_SLOT_SEL_O   <= `SLOT_3_4;
			SPDIF_EN_O         <= 1'b0;
			VALIDITY_O         <= 1'b0;
			DAC_RATE_O         <= `RATE_48K;
			ADC_RATE_O         <= `RATE_48K;
		end else begin
			spdif_config_ok_q             <= rate_ok & slot_ok & ~drs_q; // R17
			EXT_AMP_SHUTDOWN_O <= ext_amp_q; // R8
			DIGITAL_LOOPBACK_O <= loopback_q; // R21
			VAR_RATE_O         <= vra_q; // R14
			DAC_SLOT_SEL_O     <= dsa_q; // R11
			SPDIF_SLOT_SEL_O   <= spsa_q;
			SPDIF_EN_O         <= spdif_en_q; // R15
			VALIDITY_O         <= flag_q | (~validity_override_q & SAMPLE_ERR_I); // R18
			DAC_RATE_O         <= vra_q ? dac_rate_q : `RATE_48K; // R14
			ADC_RATE_O         <= vra_q ? adc_rate_q : `RATE_48K; // R14
		end
	end

	// ==========================================================
	// read mux, data one cycle after the strobe
	reg [15:0] rd_d;

	always @* begin
		case (ADDR_I)
			`OFS_GENERAL_PURPOSE:
				rd_d = {8'h00, loopback_q, 7'h00};
			`OFS_POWER_DOWN:
				rd_d = {ext_amp_q, req_q, 4'h0,
				        ref_rdy_q, mix_rdy_q, dac_rdy_q, adc_rdy_q}; // R1
			`OFS_EXT_CAP_ID:
				rd_d = {cfg_q, 2'h0, `CAP_COMPLIANCE, `CAP_SLOT_MAP, 3'h0, // R12 R13
				        dsa_q, 1'b0, `CAP_SPDIF, 1'b0, `CAP_VAR_RATE}; // R10
			`OFS_EXT_STAT_CTRL:
				rd_d = {validity_override_q, 4'h0, spdif_config_ok_q, 4'h0, spsa_q,
				        1'b0, spdif_en_q, 1'b0, vra_q}; // R15
			`OFS_FRONT_DAC_RATE:
				rd_d = dac_rate_q;
			`OFS_ADC_RATE:
				rd_d = adc_rate_q;
			`OFS_SPDIF_CTRL:
				rd_d = {flag_q, 1'b0, spdif_tx_rate_sel_q, 12'h000};
			`OFS_RATE_MODE:
				rd_d = {15'h0000, drs_q};
			default:
				rd_d = 16'h0000;
		endcase
	end

	// read data register, zero outside read cycles
	always @(posedge CLK_I) begin
		if (RST_I)
			RDATA_O <= 16'h0000;
		else if (RE_I)
			RDATA_O <= rd_d;
		else
			RDATA_O <= 16'h0000;
	end

endmodule
`default_nettype wire

// >>> codec_regs_defines.vh
// register offsets, field positions, reset values and fixed codes of the codec register bank
`ifndef CODEC_REGS_DEFINES_VH
`define CODEC_REGS_DEFINES_VH

// ==========================================================
// register offsets
`define OFS_GENERAL_PURPOSE   7'h20
`define OFS_POWER_DOWN        7'h26
`define OFS_EXT_CAP_ID        7'h28
`define OFS_EXT_STAT_CTRL     7'h2A
`define OFS_FRONT_DAC_RATE    7'h2C
`define OFS_ADC_RATE          7'h32
`define OFS_SPDIF_CTRL        7'h3A
`define OFS_RATE_MODE         7'h6A

// ==========================================================
// general purpose register fields
`define GP_LOOPBACK_BIT       7

// ==========================================================
// power-down register fields
`define PD_EXT_AMP_BIT        15
`define PD_REQ_HI             14
`define PD_REQ_LO             8

// ==========================================================
// extended capability id fixed codes
`define CAP_COMPLIANCE        2'h1
`define CAP_SLOT_MAP          1'h1
`define CAP_SPDIF             1'h1
`define CAP_VAR_RATE          1'h1

// ==========================================================
// extended status / control fields, and the DAC slot field of the extended capability id
`define ESC_VALIDITY_OVERRIDE_BIT        15
`define ESC_SPSA_HI           5
`define ESC_SPSA_LO           4
`define ESC_SPDIF_BIT         2
`define ESC_VRA_BIT           0
`define DSA_HI                5
`define DSA_LO                4

// ==========================================================
// spdif control fields and encodings, and the rate mode field
`define SPC_FLAG_BIT          15
`define SPC_RATE_HI           13
`define SPC_RATE_LO           12
`define SPDIF_TX_RATE_SEL_44K1             2'h0
`define SPDIF_TX_RATE_SEL_48K              2'h2
`define SPDIF_TX_RATE_SEL_RESET            2'h2
`define RM_DRS_BIT            0

// ==========================================================
// sample rates in hertz
`define RATE_48K              16'hBB80
`define RATE_44K1             16'hAC44
`define RATE_MIN              16'h1B58

// ==========================================================
// slot select and configuration codes
`define SLOT_3_4              2'h0
`define SLOT_7_8              2'h1
`define SLOT_6_9              2'h2
`define SLOT_10_11            2'h3
`define CFG_PRIMARY           2'h0
`define CFG_SECONDARY_3       2'h3

`endif

// >>> analog_model.sv
// behavioural model of one analog subsection settling after power-up
`timescale 1ns/1ps
`default_nettype none
module analog_model (
	// clock
	input  wire logic clk_i,
	// power-down level from the register bank
	input  wire logic pwrdn_i,
	// settled level back to the register bank
	output logic      settled_o
);
	logic [3:0] up_q = 4'h0;
	// settles four cycles after power-up, drops on the first edge of power-down
	always @(posedge clk_i) begin
		up_q <= pwrdn_i ? 4'h0 : {up_q[2:0], 1'b1};
	end
	assign settled_o = up_q[3];
endmodule
`default_nettype wire

// >>> codec_regs_asserts.sv
// concurrent checks on the ports of the codec register bank
`timescale 1ns/1ps
`default_nettype none
module codec_regs_asserts (
	// clock and reset
	input wire logic        CLK_I,
	input wire logic        RST_I,
	// register port
	input wire logic [6:0]  ADDR_I,
	input wire logic [15:0] WDATA_I,
	input wire logic        WE_I,
	input wire logic        RE_I,
	input wire logic [15:0] RDATA_O,
	// analog side and controls
	input wire logic        ADC_SETTLED_I,
	input wire logic        ADC_PWRDN_O,
	input wire logic        DAC_PWRDN_O,
	input wire logic        REF_PWRDN_O,
	input wire logic        LINK_PWRDN_O,
	input wire logic        CLK_STOP_O,
	input wire logic        EXT_AMP_SHUTDOWN_O,
	input wire logic        DIGITAL_LOOPBACK_O,
	input wire logic [15:0] DAC_RATE_O,
	input wire logic [15:0] ADC_RATE_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	// ==========================================================
	// write and read steps
	sequence s_wr(a);
		WE_I && ADDR_I == a;
	endsequence
	sequence s_rd(a);
		RE_I && ADDR_I == a;
	endsequence
	a_amp_pin_follow: assert property (s_wr(7'h26) |-> ##2 EXT_AMP_SHUTDOWN_O == $past(WDATA_I[15], 2))
		else $error("amplifier pin does not follow its bit");
	a_loopback_follow: assert property (s_wr(7'h20) |-> ##2 DIGITAL_LOOPBACK_O == $past(WDATA_I[7], 2))
		else $error("loopback output does not follow its bit");
	a_vra_off_rates: assert property (s_wr(7'h2A) ##0 !WDATA_I[0] |-> ##2 DAC_RATE_O == 16'hBB80 && ADC_RATE_O == 16'hBB80)
		else $error("rates not back at 48 kHz");
	a_ext_id_fixed: assert property (s_rd(7'h28) |=> RDATA_O[11:9] == 3'h3 && RDATA_O[2] && RDATA_O[0])
		else $error("capability bits wrong");
	a_ready_low: assert property (!ADC_SETTLED_I [*3] ##0 s_rd(7'h26) |=> !RDATA_O[0])
		else $error("ADC ready while not settled");
	a_rdata_idle: assert property (!$past(RE_I) |-> RDATA_O == 16'h0000)
		else $error("read data outside read slot");
	a_ref_gate: assert property (REF_PWRDN_O |-> ADC_PWRDN_O && DAC_PWRDN_O)
		else $error("reference down with converters up");
	a_clock_stop: assert property (CLK_STOP_O |-> ADC_PWRDN_O && DAC_PWRDN_O && LINK_PWRDN_O)
		else $error("clocks stopped too early");
	a_rate_range: assert property (DAC_RATE_O >= 16'h1B58 && DAC_RATE_O <= 16'hBB80
		&& ADC_RATE_O >= 16'h1B58 && ADC_RATE_O <= 16'hBB80)
		else $error("rate out of range");
endmodule
bind codec_regs codec_regs_asserts chk (.CLK_I, .RST_I, .ADDR_I, .WDATA_I, .WE_I, .RE_I, .RDATA_O,
	.ADC_SETTLED_I, .ADC_PWRDN_O, .DAC_PWRDN_O, .REF_PWRDN_O, .LINK_PWRDN_O, .CLK_STOP_O,
	.EXT_AMP_SHUTDOWN_O, .DIGITAL_LOOPBACK_O, .DAC_RATE_O, .ADC_RATE_O);
`default_nettype wire

// >>> codec_power_rate_spdif_regs_bench.sv
// self-checking bench for the codec register bank
`timescale 1ns/1ps
`default_nettype none
module codec_power_rate_spdif_regs_bench;
	logic CLK_I = 0, RST_I = 1, WE_I = 0, RE_I = 0, SPDIF_STRAP_N_I = 0, SAMPLE_ERR_I = 0;
	logic PRIMARY_REQ4_I = 0, PRIMARY_REQ5_I = 0;
	logic [1:0] CFG_STRAP_I = 2'h0;
	logic [6:0] ADDR_I = 7'h00;
	logic [15:0] WDATA_I = 16'h0000;
	wire [15:0] RDATA_O, DAC_RATE_O, ADC_RATE_O;
	wire [1:0] DAC_SLOT_SEL_O, SPDIF_SLOT_SEL_O;
	wire ADC_SETTLED_I, DAC_SETTLED_I, MIX_SETTLED_I, REF_SETTLED_I, ADC_PWRDN_O, DAC_PWRDN_O;
	wire MIX_PWRDN_O, REF_PWRDN_O, LINK_PWRDN_O, CLK_STOP_O, HP_STANDBY_O, EXT_AMP_SHUTDOWN_O;
	wire DIGITAL_LOOPBACK_O, VAR_RATE_O, SPDIF_EN_O, VALIDITY_O;
	int failures = 0, samples_checked = 0;
	codec_regs #(.CHANNELS(2)) dut (.CLK_I, .RST_I, .ADDR_I, .WDATA_I, .WE_I, .RE_I, .RDATA_O,
		.CFG_STRAP_I, .SPDIF_STRAP_N_I, .PRIMARY_REQ4_I, .PRIMARY_REQ5_I, .ADC_SETTLED_I,
		.DAC_SETTLED_I, .MIX_SETTLED_I, .REF_SETTLED_I, .SAMPLE_ERR_I, .ADC_PWRDN_O, .DAC_PWRDN_O,
		.MIX_PWRDN_O, .REF_PWRDN_O, .LINK_PWRDN_O, .CLK_STOP_O, .HP_STANDBY_O, .EXT_AMP_SHUTDOWN_O,
		.DIGITAL_LOOPBACK_O, .VAR_RATE_O, .DAC_SLOT_SEL_O, .SPDIF_SLOT_SEL_O, .SPDIF_EN_O,
		.VALIDITY_O, .DAC_RATE_O, .ADC_RATE_O);
	// analog subsections on the far side
	analog_model m_adc (.clk_i(CLK_I), .pwrdn_i(ADC_PWRDN_O), .settled_o(ADC_SETTLED_I));
	analog_model m_dac (.clk_i(CLK_I), .pwrdn_i(DAC_PWRDN_O), .settled_o(DAC_SETTLED_I));
	analog_model m_mix (.clk_i(CLK_I), .pwrdn_i(MIX_PWRDN_O), .settled_o(MIX_SETTLED_I));
	analog_model m_ref (.clk_i(CLK_I), .pwrdn_i(REF_PWRDN_O), .settled_o(REF_SETTLED_I));
	// ==========================================================
	// bus and compare tasks
	task chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [6:0] a, input logic [15:0] d);
		WE_I <= 1'b1;
		ADDR_I <= a;
		WDATA_I <= d;
		@(posedge CLK_I);
		WE_I <= 1'b0;
		@(posedge CLK_I);
	endtask
	task rd_chk(input logic [6:0] a, input logic [15:0] exp);
		RE_I <= 1'b1;
		ADDR_I <= a;
		@(posedge CLK_I);
		RE_I <= 1'b0;
		// read data stand between the two edges; look at them mid-cycle
		@(negedge CLK_I);
		chk(RDATA_O, exp);
		@(posedge CLK_I);
	endtask
	// ==========================================================
	// scenarios
	task t_defaults;
		repeat (10) @(posedge CLK_I);
		rd_chk(7'h26, 16'h000F);
		rd_chk(7'h28, 16'h0605);
		rd_chk(7'h2A, 16'h0410);
		rd_chk(7'h2C, 16'hBB80);
		rd_chk(7'h32, 16'hBB80);
		rd_chk(7'h10, 16'h0000);
		chk({12'h0, EXT_AMP_SHUTDOWN_O, VAR_RATE_O, SPDIF_SLOT_SEL_O}, 16'h0001);
		$display("defaults done");
	endtask
	task t_slots;
		for (int i = 0; i < 4; i++) begin
			wr(7'h28, 16'hFFCF | 16'(i << 4));
			rd_chk(7'h28, 16'h0605 | 16'(i << 4));
			rd_chk(7'h2A, (i == 1) ? 16'h0010 : 16'h0410);
			chk({14'h0, DAC_SLOT_SEL_O}, 16'(i));
		end
		$display("slots done");
	endtask
	task t_power;
		logic [15:0] w [9] = '{16'h0100, 16'h0300, 16'h0B00, 16'h0300, 16'h2300, 16'h3300,
			16'h0000, 16'h0800, 16'hC000};
		logic [7:0] e [9] = '{8'h40, 8'h60, 8'h78, 8'h60, 8'h60, 8'h66, 8'h00, 8'h00, 8'h81};
		// bits go up one at a time, except the last step that sets amplifier and headphone bits together; each state settles before the next
		for (int i = 0; i < 9; i++) begin
			wr(7'h26, w[i] | 16'h000F);
			repeat (10) @(posedge CLK_I);
			chk({8'h0, EXT_AMP_SHUTDOWN_O, ADC_PWRDN_O, DAC_PWRDN_O, MIX_PWRDN_O, REF_PWRDN_O,
				LINK_PWRDN_O, CLK_STOP_O, HP_STANDBY_O}, {8'h0, e[i]});
			rd_chk(7'h26, w[i] | {12'h0, ~e[i][3], ~e[i][4], ~e[i][5], ~e[i][6]});
		end
		$display("power done");
	endtask
	task t_rates;
		wr(7'h2C, 16'h1000);
		rd_chk(7'h2C, 16'hBB80);
		wr(7'h2A, 16'h0011);
		wr(7'h2C, 16'h1B57);
		wr(7'h32, 16'h1B58);
		rd_chk(7'h2C, 16'h1B58);
		rd_chk(7'h32, 16'h1B58);
		rd_chk(7'h2A, 16'h0011);
		chk({15'h0, VAR_RATE_O}, 16'h0001);
		chk(DAC_RATE_O, 16'h1B58);
		chk(ADC_RATE_O, 16'h1B58);
		wr(7'h32, 16'hC000);
		rd_chk(7'h32, 16'hBB80);
		wr(7'h2A, 16'h0010);
		rd_chk(7'h2C, 16'hBB80);
		rd_chk(7'h32, 16'hBB80);
		chk(DAC_RATE_O, 16'hBB80);
		chk(ADC_RATE_O, 16'hBB80);
		$display("rates done");
	endtask
	task t_spdif;
		logic [3:0] vt [4] = '{4'h3, 4'h5, 4'hA, 4'h0};
		wr(7'h2A, 16'h0014);
		rd_chk(7'h2A, 16'h0414);
		chk({15'h0, SPDIF_EN_O}, 16'h0001);
		// double rate makes the setup unsupported
		wr(7'h6A, 16'h0001);
		rd_chk(7'h6A, 16'h0001);
		rd_chk(7'h2A, 16'h0014);
		wr(7'h6A, 16'h0000);
		// force, value and error level against the transmitted flag
		for (int i = 0; i < 4; i++) begin
			wr(7'h2A, {vt[i][3], 15'h0014});
			wr(7'h3A, {vt[i][2], 15'h2000});
			SAMPLE_ERR_I <= vt[i][1];
			repeat (4) @(posedge CLK_I);
			chk({15'h0, VALIDITY_O}, {15'h0, vt[i][0]});
		end
		wr(7'h20, 16'h0080);
		rd_chk(7'h20, 16'h0080);
		chk({15'h0, DIGITAL_LOOPBACK_O}, 16'h0001);
		$display("spdif done");
	endtask
	task t_secondary;
		RST_I <= 1'b1;
		SPDIF_STRAP_N_I <= 1'b1;
		CFG_STRAP_I <= 2'h3;
		repeat (5) @(posedge CLK_I);
		RST_I <= 1'b0;
		repeat (10) @(posedge CLK_I);
		rd_chk(7'h28, 16'hC605);
		rd_chk(7'h2A, 16'h0430);
		wr(7'h2A, 16'h0034);
		rd_chk(7'h2A, 16'h0430);
		chk({15'h0, SPDIF_EN_O}, 16'h0000);
		chk({14'h0, SPDIF_SLOT_SEL_O}, 16'h0003);
		PRIMARY_REQ4_I <= 1'b1;
		repeat (4) @(posedge CLK_I);
		chk({15'h0, LINK_PWRDN_O}, 16'h0001);
		// own bit 5 without own bit 4 does nothing; the primary's bit 5 stops clocks
		wr(7'h26, 16'h2300);
		repeat (6) @(posedge CLK_I);
		chk({14'h0, LINK_PWRDN_O, CLK_STOP_O}, 16'h0002);
		PRIMARY_REQ5_I <= 1'b1;
		repeat (4) @(posedge CLK_I);
		chk({14'h0, LINK_PWRDN_O, CLK_STOP_O}, 16'h0003);
		$display("secondary done");
	endtask
	task wrap_up;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// clock, main sequence and watchdog
	initial begin
		forever #4 CLK_I = ~CLK_I;
	end
	initial begin
		repeat (5) @(posedge CLK_I);
		RST_I <= 1'b0;
		t_defaults;
		t_slots;
		t_power;
		t_rates;
		t_spdif;
		t_secondary;
		wrap_up;
	end
	initial begin
		#40000;
		failures++;
		wrap_up;
	end
endmodule
`default_nettype wire
